// ==== src/gio_ports.sv ====
// general port pin block: six 8-bit ports, one 5-bit port, reset pin, prog entry
`timescale 1ns/10ps
`default_nettype none
module gio_ports
  import gio_pkg::*;
(
  // clock, reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic                 reset_pin_n,
  input  wire logic                 power_on_reset,
  input  wire logic                 programming_enable_pin_n,
  // mode
  input  wire logic                 legacy_mode,
  input  wire logic [7:0]           analog_use,
  input  wire logic                 jtag_enable,
  input  wire logic                 tap_shift_out,
  input  wire logic                 tdo_data,
  // legacy port g functions
  input  wire logic [2:0]           legacy_strobes,
  // register access
  input  wire gio_pkg::gio_bus_t    bus,
  output logic [7:0]                rdata,
  // pins
  input  wire logic [GIO_NPORT8*8-1:0] pin8_in,
  input  wire logic [4:0]           pin5_in,
  output gio_pkg::gio_pin8_t        pin8 [GIO_NPORT8],
  output gio_pkg::gio_pin5_t        pin5,
  output logic                      tdo_out,
  output logic                      tdo_oe,
  // status
  output logic                      in_reset,
  output logic                      prog_mode_ff
);
  import gio_pkg::*;

  logic [7:0] out_ff  [GIO_NPORT8];
  logic [7:0] dir_ff  [GIO_NPORT8];
  logic [7:0] pull_ff [GIO_NPORT8];
  logic [4:0] g_out_ff, g_dir_ff, g_pull_ff;
  logic [7:0] nxt_rdata;

  // async reset path: pin low, power-on reset or sync reset floats pins combinationally, except port c and port g pins 2..0 in legacy mode
  assign in_reset = rst | ~reset_pin_n | power_on_reset;

  function automatic logic bank_hit(input logic [7:0] a, input int unsigned p,
                                    input logic [1:0] sub);
    bank_hit = (a == 8'(ADR_BANK_BASE + 8'(p) * ADR_BANK_STEP + {6'h00, sub}));
  endfunction

  // port register writes
  always_ff @(posedge clock)
  begin
    if (in_reset)
    begin
      for (int p = 0; p < GIO_NPORT8; p++)
      begin
        out_ff[p]  <= RST_BYTE;
        dir_ff[p]  <= RST_BYTE;
        pull_ff[p] <= RST_BYTE;
      end
    end
    else if (clk_en && bus.wr)
    begin
      for (int p = 0; p < GIO_NPORT8; p++)
      begin
        if (bank_hit(bus.addr, p, SUB_OUT) || (p == PORT_F && bus.addr == ADR_F_OUT))
          out_ff[p] <= bus.wdata;
        if (bank_hit(bus.addr, p, SUB_DIR))
          dir_ff[p] <= bus.wdata;
        if (bank_hit(bus.addr, p, SUB_PULL))
          pull_ff[p] <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (in_reset)
    begin
      g_out_ff  <= RST_BYTE[4:0];
      g_dir_ff  <= RST_BYTE[4:0];
      g_pull_ff <= RST_BYTE[4:0];
    end
    else if (clk_en && bus.wr)
    begin
      if (bus.addr == ADR_G_OUT)
        g_out_ff <= bus.wdata[4:0];
      if (bus.addr == ADR_G_DIR)
        g_dir_ff <= bus.wdata[4:0];
      if (bus.addr == ADR_G_PULL)
        g_pull_ff <= bus.wdata[4:0];
    end
  end

  // read mux; unmapped reads zero, upper bits of port g read zero
  always_comb
  begin
    nxt_rdata = RST_BYTE;
    for (int p = 0; p < GIO_NPORT8; p++)
    begin
      if (bank_hit(bus.addr, p, SUB_OUT) || (p == PORT_F && bus.addr == ADR_F_OUT))
        nxt_rdata = out_ff[p];
      if (bank_hit(bus.addr, p, SUB_DIR))
        nxt_rdata = dir_ff[p];
      if (bank_hit(bus.addr, p, SUB_PULL))
        nxt_rdata = pull_ff[p];
      if (bank_hit(bus.addr, p, SUB_IN))
        nxt_rdata = pin8_in[p*8 +: 8];
    end
    unique case (bus.addr)
      ADR_G_IN:   nxt_rdata = {3'h0, pin5_in};
      ADR_G_DIR:  nxt_rdata = {3'h0, g_dir_ff};
      ADR_G_OUT:  nxt_rdata = {3'h0, g_out_ff};
      ADR_G_PULL: nxt_rdata = {3'h0, g_pull_ff};
      default:    ;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= RST_BYTE;
    else if (clk_en && bus.rd)
      rdata <= nxt_rdata;
  end

  // programming entry sampled only during power-on reset
  always_ff @(posedge clock)
  begin
    if (rst)
      prog_mode_ff <= 1'b0;
    else if (clk_en && power_on_reset)
      prog_mode_ff <= ~programming_enable_pin_n;
  end

  // eight-bit ports
  for (genvar p = 0; p < GIO_NPORT8; p++)
  begin : g_port8
    logic       rst_p, off_p;
    logic [7:0] force_p, dir_p;
    // legacy third port: forced output, ignores reset float
    assign rst_p   = (p == PORT_C && legacy_mode) ? 1'b0 : in_reset;
    assign dir_p   = (p == PORT_C && legacy_mode) ? 8'hff : dir_ff[p];
    // sixth port: analog pins and legacy mode never drive
    assign off_p   = (p == PORT_F) && legacy_mode;
    assign force_p = (p == PORT_F && jtag_enable)
                     ? (8'h01 << PF_TDI) | (8'h01 << PF_TMS) | (8'h01 << PF_TCK)
                     : 8'h00;
    logic [7:0] oe_raw;
    gio_pin_cell #(.W(8)) u_cell (
      .out_latch  (out_ff[p]),
      .dir        (dir_p),
      .pull_sel   (pull_ff[p]),
      .in_reset   (rst_p),
      .drive_off  (off_p),
      .pull_force (force_p),
      .pin_out    (pin8[p].out),
      .pin_oe     (oe_raw),
      .pin_pu     (pin8[p].pu)
    );
    assign pin8[p].oe = (p == PORT_F) ? (oe_raw & ~analog_use) : oe_raw;
  end

  // seventh port; legacy mode hands pins to strobes and oscillator
  logic [4:0] g_out_sel, g_dir_sel;
  logic       g_rst;
  always_comb
  begin
    g_out_sel = g_out_ff;
    g_dir_sel = g_dir_ff;
    g_rst     = in_reset;
    if (legacy_mode)
    begin
      // oscillator pins 3,4 never driven; strobes on 2..0
      g_dir_sel = 5'b00111;
      g_out_sel = {2'b00, in_reset ? G_LEGACY_RST : legacy_strobes};
      g_rst     = 1'b0;
    end
  end

  gio_pin_cell #(.W(GIO_G_W)) u_g (
    .out_latch  (g_out_sel),
    .dir        (g_dir_sel),
    .pull_sel   (legacy_mode ? 5'h00 : g_pull_ff),
    .in_reset   (g_rst),
    .drive_off  (1'b0),
    .pull_force (5'h00),
    .pin_out    (pin5.out),
    .pin_oe     (pin5.oe),
    .pin_pu     (pin5.pu)
  );

  assign tdo_out = tdo_data;
  assign tdo_oe  = jtag_enable & tap_shift_out;

  // checks
  reset_float_a: assert property (@(posedge clock)
    (in_reset && !legacy_mode) |-> (pin8[0].oe == 8'h00 && pin5.oe == 5'h00))
    else $error("port driven during reset");
  pull_input_a: assert property (@(posedge clock) disable iff (in_reset)
    (pin8[1].pu & pin8[1].oe) == 8'h00)
    else $error("pull-up on driven pin");
  legacy_c_a: assert property (@(posedge clock)
    legacy_mode |-> pin8[PORT_C].oe == 8'hff)
    else $error("third port not driven in legacy mode");
  legacy_f_a: assert property (@(posedge clock)
    legacy_mode |-> pin8[PORT_F].oe == 8'h00)
    else $error("sixth port driven in legacy mode");
  jtag_pull_a: assert property (@(posedge clock)
    jtag_enable |-> (pin8[PORT_F].pu[PF_TDI] && pin8[PORT_F].pu[PF_TMS]
                     && pin8[PORT_F].pu[PF_TCK]))
    else $error("jtag pull-ups lost");
  tdo_float_a: assert property (@(posedge clock)
    !tap_shift_out |-> !tdo_oe)
    else $error("tdo driven outside shift");
  legacy_g_a: assert property (@(posedge clock)
    (legacy_mode && in_reset) |-> (pin5.out[2:0] == G_LEGACY_RST && pin5.oe[2:0] == 3'b111))
    else $error("legacy port g reset levels wrong");
  analog_off_a: assert property (@(posedge clock)
    (pin8[PORT_F].oe & analog_use) == 8'h00)
    else $error("analog pin driven");
  g_write_a: assert property (@(posedge clock) disable iff (in_reset)
    (clk_en && bus.wr && bus.addr == ADR_G_DIR && !legacy_mode) |=>
      (legacy_mode || in_reset || pin5.oe == $past(bus.wdata[4:0])))
    else $error("port g direction not applied");
  // no attempt at the edge still in sync reset, where the flop is held clear
  prog_entry_a: assert property (@(posedge clock) disable iff (rst)
    (!rst && clk_en && power_on_reset) |=> prog_mode_ff == !$past(programming_enable_pin_n))
    else $error("programming entry wrong");
  pin_reset_a: assert property (@(posedge clock)
    !reset_pin_n |-> in_reset)
    else $error("reset pin ignored");
endmodule
`default_nettype wire

// ==== src/gio_pkg.sv ====
// package for the general port pin block: register map, widths, carriers
package gio_pkg;
  localparam int unsigned GIO_W      = 8;
  localparam int unsigned GIO_G_W    = 5;
  localparam int unsigned GIO_NPORT8 = 6;
  localparam logic [7:0] ADR_F_OUT = 8'h62;
  localparam logic [7:0] ADR_G_IN  = 8'h63;
  localparam logic [7:0] ADR_G_DIR = 8'h64;
  localparam logic [7:0] ADR_G_OUT = 8'h65;
  // per-port register bank base for ports a..f: out, dir, pull, in
  localparam logic [7:0] ADR_BANK_BASE = 8'h80;
  localparam logic [7:0] ADR_BANK_STEP = 8'h04;
  localparam logic [7:0] ADR_G_PULL    = 8'h66;
  localparam logic [1:0] SUB_OUT  = 2'h0;
  localparam logic [1:0] SUB_DIR  = 2'h1;
  localparam logic [1:0] SUB_PULL = 2'h2;
  localparam logic [1:0] SUB_IN   = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // legacy reset levels of port g pins 2..0
  localparam logic [2:0] G_LEGACY_RST = 3'b011;
  localparam int unsigned PF_TCK = 4;
  localparam int unsigned PF_TMS = 5;
  localparam int unsigned PF_TDI = 7;
  localparam int unsigned PORT_C = 2;
  localparam int unsigned PORT_F = 5;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gio_bus_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } gio_pin8_t;
  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
    logic [4:0] pu;
  } gio_pin5_t;
endpackage

// ==== src/gio_pin_cell.sv ====
// one port slice: output, enable and pull-up gating with async reset float
`timescale 1ns/10ps
`default_nettype none
module gio_pin_cell #(
  parameter int unsigned W = 8
) (
  // register state
  input  wire logic [W-1:0] out_latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] pull_sel,
  // overrides
  input  wire logic         in_reset,
  input  wire logic         drive_off,
  input  wire logic [W-1:0] pull_force,
  // pin drive
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_pu
);
  // the port registers are byte wide, so a slice can never be wider
  if (W < 1 || W > 8)
  begin : g_bad_width
    $error("gio_pin_cell width out of range");
  end
  logic [W-1:0] oe_eff;
  // combinational so reset floats the pins even with no clock
  assign oe_eff  = (in_reset || drive_off) ? '0 : dir;
  assign pin_oe  = oe_eff;
  assign pin_out = out_latch;
  // pull-up only on inputs; reset clears it unless forced
  assign pin_pu  = (in_reset ? '0 : (~dir & pull_sel)) | pull_force;
endmodule
`default_nettype wire

// ==== tb/gio_board.sv ====
// board model: resolves each port pin from device drive, board drive and pull-up
`timescale 1ns/10ps
`default_nettype none
module gio_board
  import gio_pkg::*;
(
  // clock
  input  wire logic               clock,
  // device drive
  input  wire gio_pkg::gio_pin8_t pin8 [GIO_NPORT8],
  input  wire gio_pkg::gio_pin5_t pin5,
  // board drive
  input  wire logic [47:0]        e8,
  input  wire logic [47:0]        en8,
  input  wire logic [4:0]         e5,
  input  wire logic [4:0]         en5,
  // resolved levels
  output logic      [47:0]        pin8_in,
  output logic      [4:0]         pin5_in
);
  logic tog_ff = 1'b0;
  always @(posedge clock)
  begin
    tog_ff <= !tog_ff;
  end
  // a line nobody holds wanders, so a stale level is never read back
  function automatic logic lvl(logic oe, logic o, logic en, logic e, logic pu);
    return oe ? o : en ? e : pu ? 1'b1 : tog_ff;
  endfunction
  always_comb
  begin
    for (int i = 0; i < 48; i++)
      pin8_in[i] = lvl(pin8[i/8].oe[i%8], pin8[i/8].out[i%8], en8[i], e8[i], pin8[i/8].pu[i%8]);
    for (int i = 0; i < 5; i++)
      pin5_in[i] = lvl(pin5.oe[i], pin5.out[i], en5[i], e5[i], pin5.pu[i]);
  end
endmodule
`default_nettype wire

// ==== tb/general_io_port_pins_test.sv ====
// self-checking bench for the general port pin block
`timescale 1ns/10ps
`default_nettype none
module general_io_port_pins_test;
  import gio_pkg::*;
  integer     seed = 32'h9a21;
  int         err_total = 0;
  int         total_checks = 0;
  gio_bus_t   bus;
  gio_pin8_t  pin8 [GIO_NPORT8];
  gio_pin5_t  pin5;
  logic [7:0] rdata, analog_use, o, d, q, r, m, e;
  logic [47:0] pin8_in, e8, en8;
  logic [4:0] pin5_in, e5, en5;
  logic [2:0] strobes;
  logic       clock, rst, clk_en, reset_pin_n, por, prog_n, legacy, jtag, shift, tdo_d;
  logic       tdo_out, tdo_oe, in_reset, prog_mode_ff;
  gio_ports DUT (.clock(clock), .rst(rst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
    .power_on_reset(por), .programming_enable_pin_n(prog_n), .legacy_mode(legacy),
    .analog_use(analog_use), .jtag_enable(jtag), .tap_shift_out(shift), .tdo_data(tdo_d),
    .legacy_strobes(strobes), .bus(bus), .rdata(rdata), .pin8_in(pin8_in), .pin5_in(pin5_in),
    .pin8(pin8), .pin5(pin5), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .in_reset(in_reset),
    .prog_mode_ff(prog_mode_ff));
  gio_board board (.clock(clock), .pin8(pin8), .pin5(pin5), .e8(e8), .en8(en8), .e5(e5),
    .en5(en5), .pin8_in(pin8_in), .pin5_in(pin5_in));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // idle edge after each access keeps the bus from being driven twice in one step
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clock);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    bus <= '0;
    #1;
    v = rdata;
  endtask
  function automatic logic [7:0] ad(int p, logic [1:0] s);
    return 8'(ADR_BANK_BASE + ADR_BANK_STEP * p + s);
  endfunction
  initial
  begin
    #(40 * 3000);
    err_total++;
    summarize();
  end
  initial
  begin
    {rst, reset_pin_n, por, prog_n, clk_en, legacy, jtag, shift, tdo_d} = 9'b111010000;
    {analog_use, strobes, bus, e8, en8, e5, en5} = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    por <= 1'b0;
    prog_n <= 1'b1;
    for (int p = 0; p < 6; p++)
    begin
      #1;
      chk("rst_drive", 8'h00, pin8[p].oe | pin8[p].pu);
      o = 8'($random(seed));
      d = (p == 0) ? 8'hff : 8'($random(seed));
      q = 8'($random(seed));
      wr(ad(p, SUB_OUT), o);
      wr(ad(p, SUB_DIR), d);
      wr(ad(p, SUB_PULL), q);
      chk("oe", d, pin8[p].oe);
      chk("out", o, pin8[p].out);
      chk("pu", q & ~d, pin8[p].pu);
      @(posedge clock);
      e8 <= 48'($random(seed)) << (p * 8);
      en8 <= 48'($random(seed)) << (p * 8);
      rd(ad(p, SUB_IN), r);
      m = d | en8[p*8+:8] | (q & ~d);
      e = (d & o) | (~d & en8[p*8+:8] & e8[p*8+:8]) | (~d & ~en8[p*8+:8] & q);
      chk("pin_in", e & m, r & m);
      rd(ad(p, SUB_DIR), r);
      chk("dir_back", d, r);
    end
    @(posedge clock);
    analog_use <= 8'h0f;
    #1;
    chk("analog_oe", d & 8'hf0, pin8[PORT_F].oe);
    wr(ADR_F_OUT, 8'h5a);
    chk("f_out", 8'h5a, pin8[PORT_F].out);
    wr(ADR_G_OUT, 8'hff);
    wr(ADR_G_DIR, 8'h15);
    wr(ADR_G_PULL, 8'hff);
    chk("g_drive", 8'h15, {3'h0, pin5.oe});
    chk("g_pu", 8'h0a, {3'h0, pin5.pu});
    @(posedge clock);
    e5 <= 5'h02;
    en5 <= 5'h0a;
    rd(ADR_G_IN, r);
    chk("g_in", 8'h17, r);
    rd(8'h70, r);
    chk("unmapped", 8'h00, r);
    @(posedge clock);
    clk_en <= 1'b0;
    prog_n <= 1'b0;
    wr(ADR_G_DIR, 8'h00);
    chk("gated_wr", 8'h15, {3'h0, pin5.oe});
    chk("prog_mode", 8'h01, {7'h0, prog_mode_ff});
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clock);
      shift <= s[0];
      jtag <= 1'b1;
      tdo_d <= 1'b1;
      #1;
      chk("tdo", {6'h0, s[0], s[0]}, {6'h0, tdo_oe, tdo_oe & tdo_out});
    end
    @(posedge clock);
    jtag <= 1'b1;
    reset_pin_n <= 1'b0;
    #1;
    for (int p = 0; p < 6; p++)
    begin
      chk("async_oe", 8'h00, pin8[p].oe);
      chk("jtag_pu", (p == PORT_F) ? 8'hb0 : 8'h00, pin8[p].pu);
    end
    chk("g_float", 8'h00, {3'h0, pin5.oe});
    chk("in_reset", 8'h01, {7'h0, in_reset});
    @(posedge clock);
    legacy <= 1'b1;
    clk_en <= 1'b1;
    #1;
    chk("c_rst", 8'hff, pin8[PORT_C].oe);
    chk("g_legacy", 8'h3b, {2'h0, pin5.oe[2:0], pin5.out[2:0]});
    @(posedge clock);
    reset_pin_n <= 1'b1;
    strobes <= 3'b101;
    wr(ad(PORT_F, SUB_DIR), 8'hff);
    chk("f_in_only", 8'h00, pin8[PORT_F].oe);
    chk("c_out_only", 8'hff, pin8[PORT_C].oe);
    chk("g_strobes", 8'h05, {3'h0, pin5.oe[4:3], pin5.out[2:0]});
    summarize();
  end
endmodule
`default_nettype wire
